// >>> logic/mdcs_top.sv
// Device control and status register bank with an AXI4-Lite slave port.
// Assumes PHY-side pins are asynchronous and pause and bus-master inputs
// come from logic on aclk.
// Notes on behaviour
// - Control bit 31 high holds the internal PHY in reset.
// - Written duplex and speed may be overridden by other settings and negotiation.
// - Half duplex sends carrier extension and accepts extended and burst frames.
// - Global reset restores power-on values except configuration space.
// - Packet buffer allocation keeps its value across a global reset.
// - Status bit 0 shows MAC duplex, one for full.
// - Status bit 1 shows PHY link, valid only with link-up enabled.
// - Status bit 4 set by XOFF pause, cleared by timer expiry or XON.
// - Status bits 7:6 give speed 00, 01, and 1x for gigabit.
// - Speed follows PHY unless forced by software or auto-detection.
// - Auto-detection sets MAC speed once after the PHY link rises.
// - Status bits 9:8 hold detected speed, triggerable by software.
// - Status bit 10 resets to one, set on PHY reset, cleared by writing 0.
// - Status bit 19 reads 0 when master disabled and nothing pending.
// - Wake advertisement control gates the auxiliary power indication.
// - Low power states downshift PHY speed unless the disable bit is set.
// - Link recognition, transmit and receive need link-up enable set.
// - Writing control bit 26 starts global reset; the bit self-clears.
`timescale 1ns/100ps
module mdcs_top
  import mdcs_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`MDCS_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`MDCS_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic phy_link,
  input wire logic phy_full_duplex,
  input wire logic [1:0] phy_speed_indication,
  input wire logic [1:0] line_speed_sensed,
  input wire logic auxiliary_power_present,
  input wire logic fc_symmetric,
  input wire logic xoff_received,
  input wire logic xon_received,
  input wire logic pause_timer_expired,
  input wire logic master_requests_pending,
  input wire logic low_power_state,
  input wire logic low_power_speed_downshift_disable,
  output logic internal_phy_reset,
  output logic device_reset_active,
  output logic mac_traffic_enable,
  output logic full_duplex_flag,
  output logic [1:0] mac_speed,
  output logic carrier_extension_enable,
  output logic burst_receive_enable,
  output logic cold_wake_advertised,
  output logic speed_downshift_enable,
  output logic [31:0] packet_buffer_allocation
);
  localparam int PIN_W = 7;

  function automatic logic addr_is(input mdcs_addr_t addr, input mdcs_addr_t off);
    addr_is = (addr[`MDCS_ADDR_W-1:2] == off[`MDCS_ADDR_W-1:2]);
  endfunction : addr_is

  function automatic logic addr_mapped(input mdcs_addr_t addr);
    addr_mapped = addr_is(addr, `MDCS_OFF_CTRL) | addr_is(addr, `MDCS_OFF_STATUS) |
      addr_is(addr, `MDCS_OFF_EXT) | addr_is(addr, `MDCS_OFF_PBA);
  endfunction : addr_mapped

  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_meta_r;
  logic [PIN_W-1:0] pin_sync_r;
  mdcs_link_if lnk ();

  mdcs_word_t ctrl_r;
  logic master_disable_r;
  logic asd_trigger_r;
  logic phy_reset_seen_flag_r;
  mdcs_word_t pba_r;
  logic grst_r;
  mdcs_cnt_t grst_cnt_r;
  logic core_rst_n;

  logic aw_held_r;
  logic w_held_r;
  mdcs_addr_t awaddr_r;
  mdcs_word_t wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  mdcs_word_t rdata_r;
  logic wr_fire;
  mdcs_word_t wr_mask;
  mdcs_word_t ctrl_nxt;
  mdcs_word_t status_word;

  // Asynchronous pins go through two flip-flops before anything reads them.
  assign pin_raw = {auxiliary_power_present, line_speed_sensed, phy_speed_indication,
    phy_full_duplex, phy_link};

  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi++) begin : g_sync
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          pin_meta_r[gi] <= 1'b0;
          pin_sync_r[gi] <= 1'b0;
        end else begin
          pin_meta_r[gi] <= pin_raw[gi];
          pin_sync_r[gi] <= pin_meta_r[gi];
        end
      end
    end
  endgenerate

  // Global reset stretch: counted on the power-on reset only, so it always ends.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      grst_r <= 1'b0;
      grst_cnt_r <= '0;
    end else if (grst_r) begin
      grst_cnt_r <= mdcs_cnt_t'(grst_cnt_r + 1'b1);
      if (grst_cnt_r == mdcs_cnt_t'(`MDCS_GRST_CYCLES - 1)) begin
        grst_r <= 1'b0;
      end
    end else if (wr_fire && addr_is(awaddr_r, `MDCS_OFF_CTRL) && wr_mask[`MDCS_CTRL_GRST] &&
                 wdata_r[`MDCS_CTRL_GRST]) begin
      grst_r <= 1'b1;
      grst_cnt_r <= '0;
    end
  end

  // Everything but the bus slave, the stretch counter, the buffer allocation, the pin synchronisers
  // and the output registers returns to power-on values; the bus stays alive so software can poll.
  assign core_rst_n = aresetn & ~grst_r;

  // AXI4-Lite write side: address and data are taken independently.
  assign s_axi_awready = ~aw_held_r & ~bvalid_r;
  assign s_axi_wready = ~w_held_r & ~bvalid_r;
  assign wr_fire = aw_held_r & w_held_r & ~bvalid_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      awaddr_r <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r <= 1'b1;
      awaddr_r <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      wdata_r <= '0;
      wstrb_r <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= `MDCS_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r <= addr_mapped(awaddr_r) ? `MDCS_RESP_OKAY : `MDCS_RESP_DECERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  assign wr_mask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  assign ctrl_nxt = ((ctrl_r & ~wr_mask) | (wdata_r & wr_mask)) & `MDCS_CTRL_WMASK;

  always_ff @(posedge aclk) begin
    if (!core_rst_n) begin
      ctrl_r <= `MDCS_CTRL_RST_VAL;
    end else if (wr_fire && addr_is(awaddr_r, `MDCS_OFF_CTRL)) begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // The detection trigger is a one-cycle strobe and reads back as zero.
  always_ff @(posedge aclk) begin
    if (!core_rst_n) begin
      master_disable_r <= 1'b0;
      asd_trigger_r <= 1'b0;
    end else begin
      asd_trigger_r <= wr_fire && addr_is(awaddr_r, `MDCS_OFF_EXT) && wstrb_r[0] &&
        wdata_r[`MDCS_EXT_SPEED_DETECT_TRIGGER];
      if (wr_fire && addr_is(awaddr_r, `MDCS_OFF_EXT) && wstrb_r[0]) begin
        master_disable_r <= wdata_r[`MDCS_EXT_MDIS];
      end
    end
  end

  // Held in reset the PHY keeps the flag set, even against a clearing write.
  always_ff @(posedge aclk) begin
    if (!core_rst_n) begin
      phy_reset_seen_flag_r <= 1'b1;
    end else if (ctrl_r[`MDCS_CTRL_PHYRST]) begin
      phy_reset_seen_flag_r <= 1'b1;
    end else if (wr_fire && addr_is(awaddr_r, `MDCS_OFF_STATUS) && wstrb_r[1] &&
                 !wdata_r[`MDCS_ST_PHY_RESET_SEEN_FLAG]) begin
      phy_reset_seen_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pba_r <= `MDCS_PBA_RST_VAL;
    end else if (wr_fire && addr_is(awaddr_r, `MDCS_OFF_PBA)) begin
      pba_r <= (pba_r & ~wr_mask) | (wdata_r & wr_mask);
    end
  end

  always_comb begin
    status_word = '0;
    status_word[`MDCS_ST_FD] = lnk.mac_fd;
    status_word[`MDCS_ST_LU] = lnk.link_established;
    status_word[`MDCS_ST_TRANSMIT_PAUSED] = lnk.transmit_paused;
    status_word[`MDCS_ST_SPD_HI:`MDCS_ST_SPD_LO] = lnk.mac_speed;
    status_word[`MDCS_ST_DETECTED_SPEED_VALUE_HI:`MDCS_ST_DETECTED_SPEED_VALUE_LO] = lnk.asd_value;
    status_word[`MDCS_ST_PHY_RESET_SEEN_FLAG] = phy_reset_seen_flag_r;
    status_word[`MDCS_ST_MASTER] = ~(master_disable_r & ~master_requests_pending);
  end

  // AXI4-Lite read side: one read in flight, answered the cycle after it is taken.
  assign s_axi_arready = ~rvalid_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rresp_r <= `MDCS_RESP_OKAY;
      rdata_r <= '0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      rresp_r <= addr_mapped(s_axi_araddr) ? `MDCS_RESP_OKAY : `MDCS_RESP_DECERR;
      if (addr_is(s_axi_araddr, `MDCS_OFF_CTRL)) begin
        rdata_r <= ctrl_r | {5'h00, grst_r, 26'h0000000};
      end else if (addr_is(s_axi_araddr, `MDCS_OFF_STATUS)) begin
        rdata_r <= status_word;
      end else if (addr_is(s_axi_araddr, `MDCS_OFF_EXT)) begin
        rdata_r <= {30'h00000000, master_disable_r, 1'b0};
      end else if (addr_is(s_axi_araddr, `MDCS_OFF_PBA)) begin
        rdata_r <= pba_r;
      end else begin
        rdata_r <= '0;
      end
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign lnk.link_up_enable = ctrl_r[`MDCS_CTRL_SLU];
  assign lnk.force_speed = ctrl_r[`MDCS_CTRL_FRCSPD];
  assign lnk.force_duplex = ctrl_r[`MDCS_CTRL_FRCDPLX];
  assign lnk.ctrl_fd = ctrl_r[`MDCS_CTRL_FD];
  assign lnk.ctrl_speed = ctrl_r[`MDCS_CTRL_SPD_HI:`MDCS_CTRL_SPD_LO];
  assign lnk.auto_speed_detect_enable = ctrl_r[`MDCS_CTRL_AUTO_SPEED_DETECT_ENABLE];
  assign lnk.asd_trigger = asd_trigger_r;
  assign lnk.phy_link = pin_sync_r[0];
  assign lnk.phy_fd = pin_sync_r[1];
  assign lnk.phy_speed = pin_sync_r[3:2];
  assign lnk.sensed_speed = pin_sync_r[5:4];
  assign lnk.fc_symmetric = fc_symmetric;
  assign lnk.xoff_rx = xoff_received;
  assign lnk.xon_rx = xon_received;
  assign lnk.pause_expired = pause_timer_expired;

  mdcs_link_resolve mdcs_link_resolve_i (
    .aclk(aclk),
    .rst_n(core_rst_n),
    .lnk(lnk)
  );

  // Outputs are all registered so downstream MAC logic sees clean levels.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      internal_phy_reset <= 1'b0;
      mac_traffic_enable <= 1'b0;
      full_duplex_flag <= 1'b0;
      mac_speed <= 2'h0;
      carrier_extension_enable <= 1'b0;
      burst_receive_enable <= 1'b0;
      cold_wake_advertised <= 1'b0;
      speed_downshift_enable <= 1'b0;
    end else begin
      internal_phy_reset <= ctrl_r[`MDCS_CTRL_PHYRST];
      mac_traffic_enable <= lnk.link_established;
      full_duplex_flag <= lnk.mac_fd;
      mac_speed <= lnk.mac_speed;
      carrier_extension_enable <= ~lnk.mac_fd;
      burst_receive_enable <= ~lnk.mac_fd;
      cold_wake_advertised <= ctrl_r[`MDCS_CTRL_ADVWAKE] & pin_sync_r[6];
      speed_downshift_enable <= low_power_state & ~low_power_speed_downshift_disable;
    end
  end

  assign device_reset_active = grst_r;
  assign packet_buffer_allocation = pba_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
endmodule : mdcs_top

// >>> logic/mdcs_map.svh
// Register map, field positions, reset values and timing counts of the
// device control and status bank. Included by the package, the checker and the bench.
`ifndef MDCS_MAP_SVH
`define MDCS_MAP_SVH

`define MDCS_ADDR_W 16
`define MDCS_OFF_CTRL 16'h0000
`define MDCS_OFF_STATUS 16'h0008
`define MDCS_OFF_EXT 16'h0018
`define MDCS_OFF_PBA 16'h1000

`define MDCS_CTRL_FD 0
`define MDCS_CTRL_AUTO_SPEED_DETECT_ENABLE 5
`define MDCS_CTRL_SLU 6
`define MDCS_CTRL_SPD_LO 8
`define MDCS_CTRL_SPD_HI 9
`define MDCS_CTRL_FRCSPD 11
`define MDCS_CTRL_FRCDPLX 12
`define MDCS_CTRL_ADVWAKE 20
`define MDCS_CTRL_GRST 26
`define MDCS_CTRL_PHYRST 31
`define MDCS_CTRL_RST_VAL 32'h0010_0200
`define MDCS_CTRL_WMASK 32'hD810_1B61

`define MDCS_ST_FD 0
`define MDCS_ST_LU 1
`define MDCS_ST_TRANSMIT_PAUSED 4
`define MDCS_ST_SPD_LO 6
`define MDCS_ST_SPD_HI 7
`define MDCS_ST_DETECTED_SPEED_VALUE_LO 8
`define MDCS_ST_DETECTED_SPEED_VALUE_HI 9
`define MDCS_ST_PHY_RESET_SEEN_FLAG 10
`define MDCS_ST_MASTER 19

`define MDCS_EXT_SPEED_DETECT_TRIGGER 0
`define MDCS_EXT_MDIS 1

`define MDCS_PBA_RST_VAL 32'h0000_0014

`define MDCS_RESP_OKAY 2'h0
`define MDCS_RESP_DECERR 2'h3

`define MDCS_CLK_PERIOD_NS 10
`define MDCS_GRST_TIME_NS 1000
`define MDCS_GRST_CYCLES (`MDCS_GRST_TIME_NS / `MDCS_CLK_PERIOD_NS)
`define MDCS_GRST_CNT_W 8

`endif

// >>> logic/mdcs_pkg.sv
// Types shared by the control and status bank and its link resolver.
// Assumes mdcs_map.svh is on the include path.
`include "mdcs_map.svh"
package mdcs_pkg;
  typedef logic [31:0] mdcs_word_t;
  typedef logic [1:0] mdcs_speed_t;
  typedef logic [`MDCS_ADDR_W-1:0] mdcs_addr_t;
  typedef logic [`MDCS_GRST_CNT_W-1:0] mdcs_cnt_t;
endpackage : mdcs_pkg

// >>> logic/mdcs_link_if.sv
// Carrier between the register bank and the link resolver.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface mdcs_link_if;
  import mdcs_pkg::*;
  logic link_up_enable;
  logic force_speed;
  logic force_duplex;
  logic ctrl_fd;
  mdcs_speed_t ctrl_speed;
  logic auto_speed_detect_enable;
  logic asd_trigger;
  logic phy_link;
  logic phy_fd;
  mdcs_speed_t phy_speed;
  mdcs_speed_t sensed_speed;
  logic fc_symmetric;
  logic xoff_rx;
  logic xon_rx;
  logic pause_expired;
  logic mac_fd;
  mdcs_speed_t mac_speed;
  mdcs_speed_t asd_value;
  logic link_established;
  logic transmit_paused;
  modport ctl (output link_up_enable, force_speed, force_duplex, ctrl_fd, ctrl_speed, auto_speed_detect_enable,
    asd_trigger, phy_link, phy_fd, phy_speed, sensed_speed, fc_symmetric, xoff_rx, xon_rx,
    pause_expired, input mac_fd, mac_speed, asd_value, link_established, transmit_paused);
  modport res (input link_up_enable, force_speed, force_duplex, ctrl_fd, ctrl_speed, auto_speed_detect_enable,
    asd_trigger, phy_link, phy_fd, phy_speed, sensed_speed, fc_symmetric, xoff_rx, xon_rx,
    pause_expired, output mac_fd, mac_speed, asd_value, link_established, transmit_paused);
endinterface : mdcs_link_if

// >>> logic/mdcs_link_resolve.sv
// Resolves the MAC duplex, speed, link and pause state from PHY and control inputs.
// Assumes synchronised PHY inputs and a synchronous active-low reset that also
// covers the global device reset.
`timescale 1ns/100ps
module mdcs_link_resolve
  import mdcs_pkg::*;
(
  input wire logic aclk,
  input wire logic rst_n,
  mdcs_link_if.res lnk
);
  logic link_seen;
  logic link_rise;
  logic link_d_r;
  logic phy_fd_r;
  logic mac_fd_r;
  mdcs_speed_t asd_speed_r;
  mdcs_speed_t asd_value_r;
  mdcs_speed_t mac_speed_r;
  logic link_est_r;
  logic transmit_paused_r;

  // The link indication is ignored entirely unless link-up is enabled.
  assign link_seen = lnk.phy_link & lnk.link_up_enable;
  assign link_rise = link_seen & ~link_d_r;

  always_ff @(posedge aclk) begin
    if (!rst_n) begin
      link_d_r <= 1'b0;
      link_est_r <= 1'b0;
    end else begin
      link_d_r <= link_seen;
      link_est_r <= link_seen;
    end
  end

  // Duplex from the PHY is sampled only on the asserting edge of the link.
  always_ff @(posedge aclk) begin
    if (!rst_n) begin
      phy_fd_r <= 1'b0;
    end else if (link_rise) begin
      phy_fd_r <= lnk.phy_fd;
    end
  end

  // The auto-detected speed is applied once per link-up and held after that.
  always_ff @(posedge aclk) begin
    if (!rst_n) begin
      asd_speed_r <= 2'h0;
    end else if (link_rise && lnk.auto_speed_detect_enable) begin
      asd_speed_r <= lnk.sensed_speed;
    end
  end

  always_ff @(posedge aclk) begin
    if (!rst_n) begin
      asd_value_r <= 2'h0;
    end else if ((link_rise && lnk.auto_speed_detect_enable) || lnk.asd_trigger) begin
      asd_value_r <= lnk.sensed_speed;
    end
  end

  always_ff @(posedge aclk) begin
    if (!rst_n) begin
      mac_fd_r <= 1'b0;
      mac_speed_r <= 2'h0;
    end else begin
      mac_fd_r <= lnk.force_duplex ? lnk.ctrl_fd : phy_fd_r;
      if (lnk.force_speed) begin
        mac_speed_r <= lnk.ctrl_speed;
      end else if (lnk.auto_speed_detect_enable) begin
        mac_speed_r <= asd_speed_r;
      end else begin
        mac_speed_r <= lnk.phy_speed;
      end
    end
  end

  // A pause request in the same cycle as a release keeps transmission paused.
  always_ff @(posedge aclk) begin
    if (!rst_n) begin
      transmit_paused_r <= 1'b0;
    end else if (lnk.fc_symmetric && lnk.xoff_rx) begin
      transmit_paused_r <= 1'b1;
    end else if (lnk.pause_expired || lnk.xon_rx || !lnk.fc_symmetric) begin
      transmit_paused_r <= 1'b0;
    end
  end

  assign lnk.mac_fd = mac_fd_r;
  assign lnk.mac_speed = mac_speed_r;
  assign lnk.asd_value = asd_value_r;
  assign lnk.link_established = link_est_r;
  assign lnk.transmit_paused = transmit_paused_r;
endmodule : mdcs_link_resolve

// >>> verif/mdcs_top_asserts.sv
// Concurrent checks on the control and status bank, seeing only top-level ports.
// Assumes mdcs_map.svh on the include path and a free-running aclk.
`timescale 1ns/100ps
`include "mdcs_map.svh"
module mdcs_top_asserts
  import mdcs_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`MDCS_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic phy_link,
  input wire logic auxiliary_power_present,
  input wire logic low_power_state,
  input wire logic low_power_speed_downshift_disable,
  input wire logic internal_phy_reset,
  input wire logic device_reset_active,
  input wire logic mac_traffic_enable,
  input wire logic full_duplex_flag,
  input wire logic [1:0] mac_speed,
  input wire logic carrier_extension_enable,
  input wire logic burst_receive_enable,
  input wire logic cold_wake_advertised,
  input wire logic speed_downshift_enable
);
  localparam int GRST_CYC = `MDCS_GRST_CYCLES;
  logic rd_st;
  logic live_r;
  mdcs_cnt_t act_cnt;
  logic [2:0] h0;
  logic [2:0] h1;
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      rd_st <= (s_axi_araddr == `MDCS_OFF_STATUS);
    end
  end
  // Half-duplex and downshift outputs are only compared once neither reset touched the previous edge.
  always_ff @(posedge aclk) live_r <= aresetn && !device_reset_active;
  always_ff @(posedge aclk) act_cnt <= (aresetn && device_reset_active) ? act_cnt + 1'h1 : '0;
  always_ff @(posedge aclk) h0 <= {full_duplex_flag, mac_speed};
  always_ff @(posedge aclk) h1 <= h0;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  halfdup_ext_a: assert property (live_r |-> carrier_extension_enable == !full_duplex_flag
    && burst_receive_enable == !full_duplex_flag) else $error("half duplex modes wrong");
  downshift_a: assert property (live_r |-> speed_downshift_enable ==
    $past(low_power_state && !low_power_speed_downshift_disable)) else $error("downshift wrong");
  cold_wake_a: assert property (!auxiliary_power_present [*4] |=> !cold_wake_advertised)
    else $error("wake advertised without aux power");
  traffic_gate_a: assert property (!phy_link [*5] |=> !mac_traffic_enable)
    else $error("traffic enabled without link");
  grst_len_a: assert property ($fell(device_reset_active) |-> act_cnt == GRST_CYC)
    else $error("global reset stretch length wrong");
  st_resv_a: assert property ($rose(s_axi_rvalid) && rd_st |->
    (s_axi_rdata & 32'hFFF7_F82C) == 0) else $error("reserved status bits set");
  st_duplex_a: assert property ($rose(s_axi_rvalid) && rd_st && h0 == h1
    && h0 == {full_duplex_flag, mac_speed} |-> s_axi_rdata[0] == full_duplex_flag)
    else $error("status duplex differs from MAC");
  st_speed_a: assert property ($rose(s_axi_rvalid) && rd_st && h0 == h1
    && h0 == {full_duplex_flag, mac_speed} |-> s_axi_rdata[7:6] == mac_speed)
    else $error("status speed differs from MAC");
  phy_reset_seen_flag_set_a: assert property ($rose(s_axi_rvalid) && rd_st && $past(internal_phy_reset)
    |-> s_axi_rdata[10]) else $error("phy reset flag not set");
  cover property (device_reset_active);
  cover property ($rose(s_axi_rvalid) && rd_st);
  cover property ($rose(full_duplex_flag));
endmodule : mdcs_top_asserts

bind mdcs_top mdcs_top_asserts mdcs_top_asserts_i (.aclk, .aresetn, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .phy_link,
  .auxiliary_power_present, .low_power_state, .low_power_speed_downshift_disable,
  .internal_phy_reset, .device_reset_active, .mac_traffic_enable, .full_duplex_flag,
  .mac_speed, .carrier_extension_enable, .burst_receive_enable, .cold_wake_advertised,
  .speed_downshift_enable);

// >>> verif/mdcs_top_test.sv
// Self-checking bench for the control and status bank over AXI4-Lite.
// Assumes the design package, header and checker are compiled first.
`timescale 1ns/100ps
`include "mdcs_map.svh"
module mdcs_top_test
  import mdcs_pkg::*;
;
  typedef struct packed {logic fd; logic [1:0] spd; logic [7:0] exp; logic [7:0] msk;} mdcs_row_s;
  mdcs_row_s rows [4] = '{'{1'h0, 2'h0, 8'h02, 8'hC3}, '{1'h1, 2'h1, 8'h43, 8'hC3},
    '{1'h0, 2'h2, 8'h82, 8'hC3}, '{1'h1, 2'h3, 8'h83, 8'h83}};
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  mdcs_addr_t s_axi_awaddr = '0;
  mdcs_addr_t s_axi_araddr = '0;
  mdcs_word_t s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic phy_link = 1'h0, phy_full_duplex = 1'h0, auxiliary_power_present = 1'h1;
  logic fc_symmetric = 1'h1, xoff_received = 1'h0, xon_received = 1'h0;
  logic pause_timer_expired = 1'h0, master_requests_pending = 1'h1;
  logic low_power_state = 1'h0, low_power_speed_downshift_disable = 1'h0;
  logic [1:0] phy_speed_indication = 2'h0, line_speed_sensed = 2'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, mac_speed, r;
  mdcs_word_t s_axi_rdata, packet_buffer_allocation, d;
  logic internal_phy_reset, device_reset_active, mac_traffic_enable, full_duplex_flag;
  logic carrier_extension_enable, burst_receive_enable, cold_wake_advertised;
  logic speed_downshift_enable;
  int bad_count = 0;
  int samples_checked = 0;

  mdcs_top mdcs_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .phy_link, .phy_full_duplex,
    .phy_speed_indication, .line_speed_sensed, .auxiliary_power_present, .fc_symmetric,
    .xoff_received, .xon_received, .pause_timer_expired, .master_requests_pending,
    .low_power_state, .low_power_speed_downshift_disable, .internal_phy_reset,
    .device_reset_active, .mac_traffic_enable, .full_duplex_flag, .mac_speed,
    .carrier_extension_enable, .burst_receive_enable, .cold_wake_advertised,
    .speed_downshift_enable, .packet_buffer_allocation);

  always #5 aclk = ~aclk;

  task automatic results();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  // Every handshake wait is bounded; a hung slave ends the run as a failure.
  task automatic tick(inout int n);
    @(posedge aclk);
    n++;
    if (n > 300) begin
      bad_count++;
      results();
    end
  endtask : tick

  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask : cyc

  task automatic wr(input mdcs_addr_t a, input mdcs_word_t v);
    int n;
    logic aw;
    logic w;
    n = 0;
    aw = 1'h0;
    w = 1'h0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(aw && w)) begin
      tick(n);
      if (!aw && s_axi_awready) begin
        aw = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (!w && s_axi_wready) begin
        w = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
    end
    do tick(n); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask : wr

  task automatic rd(input mdcs_addr_t a);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do tick(n); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do tick(n); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask : rd

  task automatic rs(input mdcs_word_t m, input mdcs_word_t e);
    rd(`MDCS_OFF_STATUS);
    chk(d & m, e);
  endtask : rs

  initial begin
    cyc(8);
    aresetn <= 1'h1;
    rd(`MDCS_OFF_CTRL);
    chk(d, `MDCS_CTRL_RST_VAL);
    rs(32'h0008_0400, 32'h0008_0400);
    wr(`MDCS_OFF_CTRL, 32'h0010_0240);
    foreach (rows[i]) begin
      phy_link <= 1'h0;
      cyc(4);
      phy_full_duplex <= rows[i].fd;
      phy_speed_indication <= rows[i].spd;
      cyc(4);
      phy_link <= 1'h1;
      cyc(8);
      rs({24'h0, rows[i].msk}, {24'h0, rows[i].exp});
      chk({30'h0, carrier_extension_enable, burst_receive_enable},
        {30'h0, {2{~rows[i].fd}}});
    end
    chk({31'h0, mac_traffic_enable}, 32'h1);
    wr(`MDCS_OFF_CTRL, 32'h0010_0200);
    cyc(4);
    chk({31'h0, mac_traffic_enable}, 32'h0);
    // Forced values agree with the PHY; the duplex latched at the last link rise must not show.
    phy_link <= 1'h0;
    phy_full_duplex <= 1'h0;
    phy_speed_indication <= 2'h2;
    wr(`MDCS_OFF_CTRL, 32'h0010_1A40);
    cyc(6);
    rs(32'hC1, 32'h80);
    wr(`MDCS_OFF_CTRL, 32'h0010_0060);
    phy_link <= 1'h0;
    line_speed_sensed <= 2'h1;
    cyc(6);
    phy_link <= 1'h1;
    cyc(8);
    rs(32'hC0, 32'h40);
    line_speed_sensed <= 2'h0;
    cyc(8);
    rs(32'hC0, 32'h40);
    line_speed_sensed <= 2'h2;
    cyc(4);
    wr(`MDCS_OFF_EXT, 32'h1);
    cyc(4);
    rs(32'h300, 32'h200);
    xoff_received <= 1'h1;
    cyc(1);
    xoff_received <= 1'h0;
    rs(32'h10, 32'h10);
    xon_received <= 1'h1;
    cyc(1);
    xon_received <= 1'h0;
    rs(32'h10, 32'h0);
    xoff_received <= 1'h1;
    cyc(1);
    xoff_received <= 1'h0;
    pause_timer_expired <= 1'h1;
    cyc(1);
    pause_timer_expired <= 1'h0;
    rs(32'h10, 32'h0);
    wr(`MDCS_OFF_CTRL, 32'h8010_0240);
    cyc(2);
    chk({31'h0, internal_phy_reset}, 32'h1);
    wr(`MDCS_OFF_STATUS, 32'hFFFF_FBFF);
    rs(32'h400, 32'h400);
    wr(`MDCS_OFF_CTRL, 32'h0010_0240);
    cyc(2);
    chk({31'h0, internal_phy_reset}, 32'h0);
    wr(`MDCS_OFF_STATUS, 32'hFFFF_FBFF);
    rs(32'hFFF7_FC2C, 32'h0);
    wr(`MDCS_OFF_EXT, 32'h2);
    rs(32'h8_0000, 32'h8_0000);
    master_requests_pending <= 1'h0;
    cyc(2);
    rs(32'h8_0000, 32'h0);
    cyc(4);
    chk({31'h0, cold_wake_advertised}, 32'h1);
    low_power_state <= 1'h1;
    wr(`MDCS_OFF_CTRL, 32'h0000_0240);
    cyc(4);
    chk({31'h0, cold_wake_advertised}, 32'h0);
    chk({31'h0, speed_downshift_enable}, 32'h1);
    low_power_speed_downshift_disable <= 1'h1;
    cyc(2);
    chk({31'h0, speed_downshift_enable}, 32'h0);
    rd(16'h0100);
    chk(d, 32'h0);
    chk({30'h0, r}, {30'h0, `MDCS_RESP_DECERR});
    wr(16'h0100, 32'hFFFF_FFFF);
    chk({30'h0, r}, {30'h0, `MDCS_RESP_DECERR});
    wr(`MDCS_OFF_CTRL, 32'h0000_0200);
    wr(`MDCS_OFF_PBA, 32'h0000_0030);
    wr(`MDCS_OFF_CTRL, 32'h0400_0000);
    cyc(1);
    chk({31'h0, device_reset_active}, 32'h1);
    cyc(110);
    rd(`MDCS_OFF_CTRL);
    chk(d, `MDCS_CTRL_RST_VAL);
    rd(`MDCS_OFF_PBA);
    chk(d, 32'h0000_0030);
    chk(packet_buffer_allocation, 32'h0000_0030);
    rs(32'h8_0400, 32'h8_0400);
    results();
  end
endmodule : mdcs_top_test
